/* File: sim/deser_model.sv */
// behavioural deserializer that frames words on the bit clock
`timescale 1ns/1ps
module deser_model
  import lvds_pattern_pkg::*;
(
  input  wire logic              i_clk_sys,
  input  wire logic              i_resetn,
  input  wire logic              i_bit_clock_pos,
  input  wire logic              i_bit_clock_neg,
  input  wire logic              i_data_lane0,
  input  wire logic              i_data_lane1,
  output logic [CODE_W-1:0]      o_word,
  output logic                   o_word_valid,
  output logic                   o_clock_fault
);
  logic [2:0] toggles;
  logic       last_pos;
  logic [5:0] sh0;
  logic [5:0] sh1;
  // framing follows the bit clock, so any whole-cycle latency is absorbed
  always @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      toggles       <= 3'h0;
      last_pos      <= 1'b1;
      sh0           <= 6'h00;
      sh1           <= 6'h00;
      o_word        <= 12'h000;
      o_word_valid  <= 1'b0;
      o_clock_fault <= 1'b0;
    end else begin
      sh0          <= {sh0[4:0], i_data_lane0};
      sh1          <= {sh1[4:0], i_data_lane1};
      last_pos     <= i_bit_clock_pos;
      o_word_valid <= 1'b0;
      if (i_bit_clock_neg !== ~i_bit_clock_pos) begin
        o_clock_fault <= 1'b1;
      end
      if (i_bit_clock_pos === last_pos) begin
        toggles <= 3'h0;
      end else begin
        toggles <= toggles + 3'h1;
        if (toggles == 3'h0 && i_bit_clock_pos) begin
          o_clock_fault <= 1'b1;
        end
        if (toggles == 3'h4) begin
          o_word_valid <= 1'b1;
          o_word       <= {sh0[4:0], i_data_lane0, sh1[4:0], i_data_lane1};
        end
      end
    end
  end
endmodule : deser_model

/* File: sim/testbench.sv */
// self-checking bench for the test pattern serializer
`timescale 1ns/1ps
module testbench;
  import lvds_pattern_pkg::*;
  logic              clk = 1'b0;
  logic              resetn = 1'b0;
  logic              smp = 1'b0;
  logic [CODE_W-1:0] conv = 12'h000;
  logic              sclk = 1'b0;
  logic              sen_n = 1'b1;
  logic              sdata = 1'b0;
  logic              bpos, bneg, lane0, lane1, wvalid, cfault;
  logic [CODE_W-1:0] word, code_a, code_b;
  int                fails = 0;
  int                compares = 0;
  int                seed = 32'h0a5b;

  always #10 clk = ~clk;
  // sample clock phase kept off the system clock edges
  initial begin
    #13;
    forever #80 smp = ~smp;
  end

  lvds_pattern_serializer DUT (.i_clk_sys(clk), .i_resetn(resetn), .i_sample_clock_pos(smp),
    .i_conv_data(conv), .i_spi_sclk(sclk), .i_spi_sen_n(sen_n), .i_spi_sdata(sdata),
    .o_bit_clock_pos(bpos), .o_bit_clock_neg(bneg), .o_data_lane0(lane0), .o_data_lane1(lane1));
  deser_model rx (.i_clk_sys(clk), .i_resetn(resetn), .i_bit_clock_pos(bpos), .i_bit_clock_neg(bneg),
    .i_data_lane0(lane0), .i_data_lane1(lane1), .o_word(word), .o_word_valid(wvalid), .o_clock_fault(cfault));

  task automatic compare_word(input logic [CODE_W-1:0] exp, input logic [CODE_W-1:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : compare_word

  task automatic compare_flag(input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : compare_flag

  task automatic complete_run;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run

  // sclk phases of 4 cycles stay above the 3-cycle minimum
  task automatic spi_write(input logic [7:0] addr, input logic [15:0] data);
    logic [23:0] frame;
    frame = {addr, data};
    sen_n <= 1'b0;
    for (int i = 23; i >= 0; i--) begin
      sdata <= frame[i];
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
      repeat (4) @(posedge clk);
      sclk <= 1'b0;
    end
    repeat (4) @(posedge clk);
    sen_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask : spi_write

  function automatic logic [15:0] select_image(input logic two, input logic fix,
                                               input logic [CODE_W-1:0] a, input logic [CODE_W-1:0] b);
    return {10'h000, two, fix, b[11:10], a[11:10]};
  endfunction : select_image

  // low 6 bits of the code registers get noise, they must be ignored
  task automatic load_pattern(input logic two, input logic fix, input logic [CODE_W-1:0] a);
    code_a = a;
    code_b = 12'($random(seed));
    spi_write(ADDR_CODE_A_LOW, {code_a[9:0], 6'($random(seed))});
    spi_write(ADDR_CODE_B_LOW, {code_b[9:0], 6'($random(seed))});
    spi_write(ADDR_SELECT_MSB, select_image(two, fix, code_a, code_b));
    repeat (24) @(posedge clk);
  endtask : load_pattern

  task automatic next_word(output logic [CODE_W-1:0] got);
    got = 'x;
    for (int n = 0; n < 40; n++) begin
      @(posedge clk);
      if (wvalid === 1'b1) begin
        got = word;
        break;
      end
    end
  endtask : next_word

  initial begin : main_seq
    logic [CODE_W-1:0] got;
    logic              on_b;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    spi_write(8'h24, 16'h0030);
    for (int k = 0; k < 10; k++) begin
      conv <= (k == 0) ? 12'hfff : (k == 1) ? 12'h000 : 12'($random(seed));
      repeat (24) @(posedge clk);
      next_word(got);
      compare_word(conv, got);
    end
    for (int k = 0; k < 4; k++) begin
      load_pattern(1'b0, 1'b1, (k == 0) ? 12'h800 : (k == 1) ? 12'h001 : 12'($random(seed)));
      conv <= 12'($random(seed));
      repeat (3) begin
        next_word(got);
        compare_word(code_a, got);
      end
    end
    for (int k = 0; k < 3; k++) begin
      load_pattern(1'b1, 1'b0, 12'($random(seed)));
      next_word(got);
      on_b = (got === code_b);
      compare_word(on_b ? code_b : code_a, got);
      repeat (5) begin
        next_word(got);
        on_b = ~on_b;
        compare_word(on_b ? code_b : code_a, got);
      end
    end
    load_pattern(1'b0, 1'b0, 12'h5a5);
    conv <= 12'h3c3;
    repeat (24) @(posedge clk);
    next_word(got);
    compare_word(12'h3c3, got);
    compare_flag(1'b0, cfault);
    complete_run();
  end

  initial begin : watchdog
    #400000;
    fails++;
    complete_run();
  end
endmodule : testbench

/* File: verilog/lvds_pattern_pkg.sv */
// constants for the lvds test pattern serializer and its serial register port
package lvds_pattern_pkg;
  localparam int          CODE_W          = 12;
  localparam int          LOW_W           = 10;
  localparam int          MSB_W           = 2;
  localparam int          LANE_BITS       = 6;
  localparam int          SPI_ADDR_W      = 8;
  localparam int          SPI_DATA_W      = 16;
  localparam int          SPI_FRAME_BITS  = SPI_ADDR_W + SPI_DATA_W;
  localparam int          SPI_CNT_W       = 5;

  localparam logic [7:0]  ADDR_SELECT_MSB = 8'h25;
  localparam logic [7:0]  ADDR_CODE_A_LOW = 8'h26;
  localparam logic [7:0]  ADDR_CODE_B_LOW = 8'h27;

  localparam int          TWO_CODE_BIT    = 5;
  localparam int          FIXED_CODE_BIT  = 4;
  localparam int          A_MSB_LO        = 0;
  localparam int          B_MSB_LO        = 2;
  localparam int          LOW_LSB         = 6;

  localparam logic [15:0] REG_RESET       = 16'h0000;
  localparam logic [2:0]  IDX_LAST        = 3'h5;
  localparam logic [2:0]  IDX_ZERO        = 3'h0;
  localparam logic [4:0]  SPI_CNT_LAST    = 5'h17;
  localparam logic [4:0]  SPI_CNT_ZERO    = 5'h00;

  typedef enum logic {
    SER_IDLE,
    SER_SHIFT
  } ser_state_t;
endpackage : lvds_pattern_pkg

/* File: verilog/lvds_pattern_serializer.sv */
// serializer with fixed and two-code test patterns, bit clock aligned to the sample clock
// How it works
// - bit clock positive leg falls first after each rising sample clock edge
// - two-code enable D5 alternates output between code A and code B
// - fixed-code enable D4 outputs code A constantly instead of conversions
// - code A bits 11:10 come from register 0x25 bits 1:0
// - code B bits 11:10 come from register 0x25 bits 3:2
// - code A bits 9:0 come from register 0x26 bits 15:6
// - code B bits 9:0 come from register 0x27 bits 15:6
`timescale 1ns/1ps
module lvds_pattern_serializer
  import lvds_pattern_pkg::*;
(
  input  wire logic              i_clk_sys,
  input  wire logic              i_resetn,
  input  wire logic              i_sample_clock_pos,
  input  wire logic [CODE_W-1:0] i_conv_data,
  input  wire logic              i_spi_sclk,
  input  wire logic              i_spi_sen_n,
  input  wire logic              i_spi_sdata,
  output logic                   o_bit_clock_pos,
  output logic                   o_bit_clock_neg,
  output logic                   o_data_lane0,
  output logic                   o_data_lane1
);
  logic [15:0]       select_msb;
  logic [15:0]       code_a_low;
  logic [15:0]       code_b_low;
  logic [2:0]        sclk_sample_reg;
  logic              sample_rise;
  logic              load;
  logic              two_code_pattern_enable;
  logic              fixed_code_pattern_enable;
  logic [CODE_W-1:0] pattern_code_a;
  logic [CODE_W-1:0] pattern_code_b;
  logic [CODE_W-1:0] word_sel;

  ser_state_t        state_reg, state_next;
  logic [2:0]        idx_reg, idx_next;
  logic [CODE_W-1:0] word_reg, word_next;
  logic              alt_reg, alt_next;
  logic              bclk_reg, bclk_next;
  logic              lane0_reg, lane0_next;
  logic              lane1_reg, lane1_next;

  spi_pattern_regs u_regs (
    .i_clk_sys    (i_clk_sys),
    .i_resetn     (i_resetn),
    .i_spi_sclk   (i_spi_sclk),
    .i_spi_sen_n  (i_spi_sen_n),
    .i_spi_sdata  (i_spi_sdata),
    .o_select_msb (select_msb),
    .o_code_a_low (code_a_low),
    .o_code_b_low (code_b_low)
  );

  // assemble a 12-bit code from its split msb and low fields
  function automatic logic [CODE_W-1:0] join_code(input logic [MSB_W-1:0] msb, input logic [LOW_W-1:0] low);
    join_code = {msb, low};
  endfunction : join_code

  assign two_code_pattern_enable   = select_msb[TWO_CODE_BIT];
  assign fixed_code_pattern_enable = select_msb[FIXED_CODE_BIT];
  assign pattern_code_a = join_code(select_msb[A_MSB_LO +: MSB_W], code_a_low[LOW_LSB +: LOW_W]);
  assign pattern_code_b = join_code(select_msb[B_MSB_LO +: MSB_W], code_b_low[LOW_LSB +: LOW_W]);

  // sample clock is a pin: two flops, the third only for edge finding
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      sclk_sample_reg <= 3'h0;
    end else begin
      sclk_sample_reg <= {sclk_sample_reg[1:0], i_sample_clock_pos};
    end
  end

  assign sample_rise = sclk_sample_reg[1] & ~sclk_sample_reg[2];
  // edge found through the synchroniser, so latency moves by whole cycles
  assign load        = sample_rise;

  // two-code wins if software breaks the exclusive use of the enables
  always_comb begin
    if (two_code_pattern_enable) begin
      word_sel = alt_reg ? pattern_code_b : pattern_code_a;
    end else if (fixed_code_pattern_enable) begin
      word_sel = pattern_code_a;
    end else begin
      word_sel = i_conv_data;
    end
  end

  always_comb begin
    state_next = state_reg;
    idx_next   = idx_reg;
    word_next  = word_reg;
    alt_next   = alt_reg;
    bclk_next  = bclk_reg;
    lane0_next = lane0_reg;
    lane1_next = lane1_reg;
    if (load) begin
      state_next = SER_SHIFT;
      idx_next   = IDX_ZERO;
      word_next  = word_sel;
      alt_next   = two_code_pattern_enable ? ~alt_reg : 1'b0;
      // stays high at the load so the first transition is a fall
      bclk_next  = 1'b1;
      lane0_next = word_sel[CODE_W-1];
      lane1_next = word_sel[LANE_BITS-1];
    end else begin
      case (state_reg)
        SER_IDLE: begin
          bclk_next = 1'b1;
        end
        SER_SHIFT: begin
          if (idx_reg == IDX_LAST) begin
            state_next = SER_IDLE;
            // back high right after the last bit, so a sample period of 7 or more cycles never sees a rise first
            bclk_next  = 1'b1;
          end else begin
            idx_next   = idx_reg + 3'h1;
            bclk_next  = ~bclk_reg;
            lane0_next = word_reg[CODE_W-2-idx_reg];
            lane1_next = word_reg[LANE_BITS-2-idx_reg];
          end
        end
        default: begin
          state_next = SER_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      state_reg <= SER_IDLE;
      idx_reg   <= IDX_ZERO;
      word_reg  <= 12'h000;
      alt_reg   <= 1'b0;
      bclk_reg  <= 1'b1;
      lane0_reg <= 1'b0;
      lane1_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      idx_reg   <= idx_next;
      word_reg  <= word_next;
      alt_reg   <= alt_next;
      bclk_reg  <= bclk_next;
      lane0_reg <= lane0_next;
      lane1_reg <= lane1_next;
    end
  end

  // negative leg is its own flop so both legs leave registers
  logic bclk_neg_reg;
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      bclk_neg_reg <= 1'b0;
    end else begin
      bclk_neg_reg <= ~bclk_next;
    end
  end

  assign o_bit_clock_pos = bclk_reg;
  assign o_bit_clock_neg = bclk_neg_reg;
  assign o_data_lane0    = lane0_reg;
  assign o_data_lane1    = lane1_reg;

  bclk_first_fall_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    load |=> o_bit_clock_pos ##1 (load || !o_bit_clock_pos))
    else $error("bit clock did not fall first after sample edge");

  bclk_legs_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    o_bit_clock_neg == !o_bit_clock_pos)
    else $error("bit clock legs not complementary");

  two_code_alt_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    load && two_code_pattern_enable |=> word_reg == ($past(alt_reg) ? $past(pattern_code_b) : $past(pattern_code_a)))
    else $error("two-code pattern did not alternate");

  fixed_code_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    load && fixed_code_pattern_enable && !two_code_pattern_enable |=> word_reg == $past(pattern_code_a) && !alt_reg)
    else $error("fixed pattern not code A");

  code_a_msb_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    load && fixed_code_pattern_enable && !two_code_pattern_enable |=> o_data_lane0 == $past(select_msb[A_MSB_LO+1]))
    else $error("code A msb not from select register bit 1");

  code_b_msb_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    load && two_code_pattern_enable && alt_reg |=> o_data_lane0 == $past(select_msb[B_MSB_LO+1]))
    else $error("code B msb not from select register bit 3");

  code_a_low_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    load && fixed_code_pattern_enable && !two_code_pattern_enable |=> o_data_lane1 == $past(code_a_low[LOW_LSB+5]))
    else $error("code A low field misplaced");

  code_b_low_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    load && two_code_pattern_enable && alt_reg |=> o_data_lane1 == $past(code_b_low[LOW_LSB+5]))
    else $error("code B low field misplaced");

  normal_data_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    load && !two_code_pattern_enable && !fixed_code_pattern_enable |=> word_reg == $past(i_conv_data))
    else $error("conversion data not serialized");

  shift_length_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    load ##1 !load [*6] |-> state_reg == SER_SHIFT ##1 state_reg == SER_IDLE)
    else $error("serial word not six bit periods long");

  bclk_idle_high_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    state_reg == SER_IDLE |-> o_bit_clock_pos)
    else $error("bit clock low while idle");

  bclk_toggle_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    state_reg == SER_SHIFT && idx_reg != IDX_LAST && !load |=> o_bit_clock_pos == !$past(o_bit_clock_pos))
    else $error("bit clock did not toggle while shifting");

  lane_order_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    load ##1 !load |=> o_data_lane0 == word_reg[CODE_W-2] && o_data_lane1 == word_reg[LANE_BITS-2])
    else $error("second bit on the lanes out of order");

  two_code_toggle_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    load && two_code_pattern_enable |=> alt_reg != $past(alt_reg))
    else $error("two-code selector did not flip");
endmodule : lvds_pattern_serializer

/* File: verilog/spi_pattern_regs.sv */
// serial write port holding the pattern select and code registers
`timescale 1ns/1ps
module spi_pattern_regs
  import lvds_pattern_pkg::*;
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_resetn,
  input  wire logic        i_spi_sclk,
  input  wire logic        i_spi_sen_n,
  input  wire logic        i_spi_sdata,
  output logic [15:0]      o_select_msb,
  output logic [15:0]      o_code_a_low,
  output logic [15:0]      o_code_b_low
);
  logic [2:0]  sclk_sync_reg;
  logic [1:0]  sen_sync_reg;
  logic [1:0]  sdata_sync_reg;
  logic [23:0] shift_reg, shift_next;
  logic [4:0]  cnt_reg, cnt_next;
  logic [15:0] sel_reg, sel_next;
  logic [15:0] a_low_reg, a_low_next;
  logic [15:0] b_low_reg, b_low_next;
  logic        sclk_rise;
  logic [23:0] frame;

  // pins are async to i_clk_sys; only stage 1 feeds stage 2
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      sclk_sync_reg  <= 3'h0;
      sen_sync_reg   <= 2'h3;
      sdata_sync_reg <= 2'h0;
    end else begin
      sclk_sync_reg  <= {sclk_sync_reg[1:0], i_spi_sclk};
      sen_sync_reg   <= {sen_sync_reg[0], i_spi_sen_n};
      sdata_sync_reg <= {sdata_sync_reg[0], i_spi_sdata};
    end
  end

  assign sclk_rise = sclk_sync_reg[1] & ~sclk_sync_reg[2];
  assign frame     = {shift_reg[22:0], sdata_sync_reg[1]};

  always_comb begin
    shift_next = shift_reg;
    cnt_next   = cnt_reg;
    sel_next   = sel_reg;
    a_low_next = a_low_reg;
    b_low_next = b_low_reg;
    if (sen_sync_reg[1]) begin
      cnt_next = SPI_CNT_ZERO;
    end else if (sclk_rise) begin
      shift_next = frame;
      if (cnt_reg == SPI_CNT_LAST) begin
        cnt_next = SPI_CNT_ZERO;
        case (frame[SPI_FRAME_BITS-1:SPI_DATA_W])
          ADDR_SELECT_MSB: sel_next   = frame[SPI_DATA_W-1:0];
          ADDR_CODE_A_LOW: a_low_next = frame[SPI_DATA_W-1:0];
          ADDR_CODE_B_LOW: b_low_next = frame[SPI_DATA_W-1:0];
          default: begin
          end
        endcase
      end else begin
        cnt_next = cnt_reg + 5'h01;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      shift_reg <= 24'h000000;
      cnt_reg   <= SPI_CNT_ZERO;
      sel_reg   <= REG_RESET;
      a_low_reg <= REG_RESET;
      b_low_reg <= REG_RESET;
    end else begin
      shift_reg <= shift_next;
      cnt_reg   <= cnt_next;
      sel_reg   <= sel_next;
      a_low_reg <= a_low_next;
      b_low_reg <= b_low_next;
    end
  end

  assign o_select_msb = sel_reg;
  assign o_code_a_low = a_low_reg;
  assign o_code_b_low = b_low_reg;
endmodule : spi_pattern_regs
